// file: rtl/rcb_pkg.sv
// Offsets, field layout, reset values and rate constants of the reference clock B bank
package rcb_pkg;

    localparam int          ADDR_W        = 12;
    localparam int          DATA_W        = 8;

    // Register byte addresses
    localparam logic [11:0] OFF_REF_CFG   = 12'h280;
    localparam logic [11:0] OFF_SUM_LOW   = 12'h2c0;
    localparam logic [11:0] OFF_SUM_MID   = 12'h300;
    localparam logic [11:0] OFF_EVT_LOW   = 12'h600;
    localparam logic [11:0] OFF_EVT_MID   = 12'h604;
    localparam logic [11:0] OFF_MSK_LOW   = 12'h608;
    localparam logic [11:0] OFF_MSK_MID   = 12'h60c;

    // Configuration field layout
    localparam int          CFG_EN_BIT    = 6;
    localparam int          CFG_RATE_BIT  = 5;
    localparam int          CFG_SEL_LSB   = 0;
    localparam int          CFG_SEL_W     = 5;
    localparam logic [7:0]  CFG_WR_MASK   = 8'h7f;

    // Reset values
    localparam logic [7:0]  CFG_RESET     = 8'h41;
    localparam logic [7:0]  SUM_RESET     = 8'h00;
    localparam logic [7:0]  EVT_RESET     = 8'h00;
    localparam logic [7:0]  MSK_RESET     = 8'h00;
    localparam logic [7:0]  RDATA_IDLE    = 8'h00;

    // Recovered channel clocks 0..21
    localparam int          NUM_REC_CH    = 22;
    localparam int          SEL_SPACE     = 32;
    localparam logic [4:0]  LAST_CH_CODE  = 5'h15;

    // Input clock rates in kHz: 1544 and 2048
    localparam logic [11:0] RATE_T1_KHZ   = 12'h608;
    localparam logic [11:0] RATE_E1_KHZ   = 12'h800;

endpackage : rcb_pkg

// file: rtl/rcb_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module rcb_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else begin
            stage1_reg <= async_in;
            stage2_reg <= stage1_reg;
        end
    end

    assign sync_out = stage2_reg;

endmodule : rcb_sync

// file: rtl/rcb_top.sv
// Reference clock B source select, channel interrupt summary and event interrupt bank
//
// Contract
// - Reference output driven when enable bit is 1 (reset); high-impedance when 0.
// - Rate bit 0 (default) marks external clock as T1, 1 as E1.
// - Five-bit select picks recovered clock of channel 0..21; resets to channel 1.
// - First summary register: bit 7 is channel 8 down to bit 0 channel 1.
// - Second summary register: bit 7 is channel 16 down to bit 0 channel 9.
// - Summary bit is 1 while channel has pending interrupt, else 0 (reset 0).
// - T1 rate means 1.544 MHz, E1 rate means 2.048 MHz.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
module rcb_top (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic [7:0]  channel_irq_flags_low,
    input  wire logic [7:0]  channel_irq_flags_mid,
    input  wire logic [21:0] recovered_clock_in,
    input  wire logic        second_external_clock_in,
    output logic             second_reference_out,
    output logic             second_reference_out_oe_n,
    output logic      [11:0] second_ext_clock_rate_khz,
    output logic             irq
);

    // Register state
    logic [7:0]  ref_cfg_reg;
    logic [7:0]  ref_cfg_next;
    logic [7:0]  evt_low_reg;
    logic [7:0]  evt_low_next;
    logic [7:0]  evt_mid_reg;
    logic [7:0]  evt_mid_next;
    logic [7:0]  msk_low_reg;
    logic [7:0]  msk_low_next;
    logic [7:0]  msk_mid_reg;
    logic [7:0]  msk_mid_next;
    logic [7:0]  flags_low_d_reg;
    logic [7:0]  flags_mid_d_reg;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        ref_out_reg;
    logic [11:0] rate_reg;
    logic [11:0] rate_next;

    // Address decode
    wire         hit_cfg     = (reg_addr == rcb_pkg::OFF_REF_CFG);
    wire         hit_sum_low = (reg_addr == rcb_pkg::OFF_SUM_LOW);
    wire         hit_sum_mid = (reg_addr == rcb_pkg::OFF_SUM_MID);
    wire         hit_evt_low = (reg_addr == rcb_pkg::OFF_EVT_LOW);
    wire         hit_evt_mid = (reg_addr == rcb_pkg::OFF_EVT_MID);
    wire         hit_msk_low = (reg_addr == rcb_pkg::OFF_MSK_LOW);
    wire         hit_msk_mid = (reg_addr == rcb_pkg::OFF_MSK_MID);

    wire         wr_cfg      = reg_wr & hit_cfg;
    wire         wr_msk_low  = reg_wr & hit_msk_low;
    wire         wr_msk_mid  = reg_wr & hit_msk_mid;
    wire         rd_evt_low  = reg_rd & hit_evt_low;
    wire         rd_evt_mid  = reg_rd & hit_evt_mid;

    // Configuration fields
    wire         ref_enable  = ref_cfg_reg[rcb_pkg::CFG_EN_BIT];
    wire         rate_is_e1  = ref_cfg_next[rcb_pkg::CFG_RATE_BIT];
    wire [4:0]   sel_field   = ref_cfg_reg[rcb_pkg::CFG_SEL_LSB +: rcb_pkg::CFG_SEL_W];

    // Reserved bit 7 is dropped on write so it reads as zero
    assign ref_cfg_next = wr_cfg ? (reg_wdata & rcb_pkg::CFG_WR_MASK) : ref_cfg_reg;
    assign msk_low_next = wr_msk_low ? reg_wdata : msk_low_reg;
    assign msk_mid_next = wr_msk_mid ? reg_wdata : msk_mid_reg;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_cfg_reg <= rcb_pkg::CFG_RESET;
            msk_low_reg <= rcb_pkg::MSK_RESET;
            msk_mid_reg <= rcb_pkg::MSK_RESET;
        end else begin
            ref_cfg_reg <= ref_cfg_next;
            msk_low_reg <= msk_low_next;
            msk_mid_reg <= msk_mid_next;
        end
    end

    // Rate report in kHz follows the rate bit
    assign rate_next = rate_is_e1 ? rcb_pkg::RATE_E1_KHZ : rcb_pkg::RATE_T1_KHZ;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rate_reg <= rcb_pkg::RATE_T1_KHZ;
        end else begin
            rate_reg <= rate_next;
        end
    end

    assign second_ext_clock_rate_khz = rate_reg;

    // Clock path: pins are asynchronous, so all pass the synchroniser
    logic [22:0] clk_pins_s;

    rcb_sync #(
        .WIDTH (rcb_pkg::NUM_REC_CH + 1)
    ) u_clk_sync (
        .clk      (clk),
        .arst_n   (arst_n),
        .async_in ({second_external_clock_in, recovered_clock_in}),
        .sync_out (clk_pins_s)
    );

    // Padded so out-of-range codes never index past the vector
    wire [31:0]  rclk_pad     = {{(rcb_pkg::SEL_SPACE - rcb_pkg::NUM_REC_CH){1'b0}},
                                 clk_pins_s[21:0]};
    wire         ext_clk_s    = clk_pins_s[22];
    wire         sel_in_range = (sel_field <= rcb_pkg::LAST_CH_CODE);
    wire         ref_src      = sel_in_range ? rclk_pad[sel_field] : ext_clk_s;

    // Sampled at 50 MHz: edges carry up to one cycle of jitter
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ref_out_reg <= 1'b0;
        end else begin
            ref_out_reg <= ref_src;
        end
    end

    assign second_reference_out      = ref_out_reg;
    assign second_reference_out_oe_n = ~ref_enable;

    // Events: a channel going pending sets a sticky bit; read clears, set wins
    wire [7:0]   evt_low = channel_irq_flags_low & ~flags_low_d_reg;
    wire [7:0]   evt_mid = channel_irq_flags_mid & ~flags_mid_d_reg;

    assign evt_low_next = (evt_low_reg & ~{8{rd_evt_low}}) | evt_low;
    assign evt_mid_next = (evt_mid_reg & ~{8{rd_evt_mid}}) | evt_mid;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flags_low_d_reg <= rcb_pkg::SUM_RESET;
            flags_mid_d_reg <= rcb_pkg::SUM_RESET;
            evt_low_reg     <= rcb_pkg::EVT_RESET;
            evt_mid_reg     <= rcb_pkg::EVT_RESET;
        end else begin
            flags_low_d_reg <= channel_irq_flags_low;
            flags_mid_d_reg <= channel_irq_flags_mid;
            evt_low_reg     <= evt_low_next;
            evt_mid_reg     <= evt_mid_next;
        end
    end

    assign irq = |({evt_mid_reg, evt_low_reg} & {msk_mid_reg, msk_low_reg});

    // Read path; summary bits are live channel state, writes to them are ignored
    wire [7:0]   rd_value = hit_cfg     ? ref_cfg_reg           :
                            hit_sum_low ? channel_irq_flags_low :
                            hit_sum_mid ? channel_irq_flags_mid :
                            hit_evt_low ? evt_low_reg           :
                            hit_evt_mid ? evt_mid_reg           :
                            hit_msk_low ? msk_low_reg           :
                            hit_msk_mid ? msk_mid_reg           :
                                          rcb_pkg::RDATA_IDLE;

    assign rdata_next = reg_rd ? rd_value : rcb_pkg::RDATA_IDLE;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= rcb_pkg::RDATA_IDLE;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    oe_follows_enable_a: assert property (
        wr_cfg |=> (second_reference_out_oe_n == !$past(reg_wdata[rcb_pkg::CFG_EN_BIT])))
        else $error("output enable does not follow enable bit");

    rate_report_a: assert property (
        wr_cfg |=> (second_ext_clock_rate_khz ==
                    ($past(reg_wdata[rcb_pkg::CFG_RATE_BIT]) ?
                     rcb_pkg::RATE_E1_KHZ : rcb_pkg::RATE_T1_KHZ)))
        else $error("rate report wrong for rate bit");

    channel_route_a: assert property (
        (!wr_cfg && sel_in_range) |=> (second_reference_out == $past(rclk_pad[sel_field])))
        else $error("output not the selected channel clock");

    ext_route_a: assert property (
        (sel_field > rcb_pkg::LAST_CH_CODE) |=> (second_reference_out == $past(ext_clk_s)))
        else $error("output not the external clock for high code");

    sum_low_read_a: assert property (
        (reg_rd && hit_sum_low) |=> (reg_rdata == $past(channel_irq_flags_low)))
        else $error("low summary read mismatch");

    sum_mid_read_a: assert property (
        (reg_rd && hit_sum_mid) |=> (reg_rdata == $past(channel_irq_flags_mid)))
        else $error("mid summary read mismatch");

    cfg_readback_a: assert property (
        (wr_cfg ##1 (reg_rd && hit_cfg && !reg_wr)) |=>
        (reg_rdata == ($past(reg_wdata, 2) & rcb_pkg::CFG_WR_MASK)))
        else $error("config readback mismatch");

    event_sticky_a: assert property (
        (evt_low != 8'h00) |=> ((evt_low_reg & $past(evt_low)) == $past(evt_low)))
        else $error("event lost on set");

    read_clear_a: assert property (
        (rd_evt_low && evt_low == 8'h00) |=> (evt_low_reg == 8'h00))
        else $error("event status not cleared by read");

    irq_cause_a: assert property (
        $rose(irq) |-> $past(evt_low != 8'h00 || evt_mid != 8'h00 || wr_msk_low || wr_msk_mid))
        else $error("interrupt rose without cause");

    rdata_idle_a: assert property (
        !reg_rd |=> (reg_rdata == rcb_pkg::RDATA_IDLE))
        else $error("read data outside read slot");

    cfg_hold_a: assert property (
        !wr_cfg |=> $stable(ref_cfg_reg))
        else $error("config changed without a write");

    cfg_read_a: assert property (
        (reg_rd && hit_cfg) |=> (reg_rdata == $past(ref_cfg_reg)))
        else $error("config read mismatch");

    oe_hold_a: assert property (
        !wr_cfg |=> $stable(second_reference_out_oe_n))
        else $error("output enable changed without a write");

    rate_hold_a: assert property (
        !wr_cfg |=> $stable(second_ext_clock_rate_khz))
        else $error("rate report changed without a write");

    rate_match_a: assert property (
        second_ext_clock_rate_khz == (ref_cfg_reg[rcb_pkg::CFG_RATE_BIT] ?
                                      rcb_pkg::RATE_E1_KHZ : rcb_pkg::RATE_T1_KHZ))
        else $error("rate report disagrees with rate bit");

    evt_low_read_a: assert property (
        rd_evt_low |=> (reg_rdata == $past(evt_low_reg)))
        else $error("low event read mismatch");

    evt_mid_read_a: assert property (
        rd_evt_mid |=> (reg_rdata == $past(evt_mid_reg)))
        else $error("mid event read mismatch");

    mask_low_write_a: assert property (
        wr_msk_low |=> (msk_low_reg == $past(reg_wdata)))
        else $error("low mask write lost");

    mask_mid_write_a: assert property (
        wr_msk_mid |=> (msk_mid_reg == $past(reg_wdata)))
        else $error("mid mask write lost");

    mask_read_a: assert property (
        (reg_rd && hit_msk_low) |=> (reg_rdata == $past(msk_low_reg)))
        else $error("low mask read mismatch");

    mask_mid_read_a: assert property (
        (reg_rd && hit_msk_mid) |=> (reg_rdata == $past(msk_mid_reg)))
        else $error("mid mask read mismatch");

    mid_sticky_a: assert property (
        (evt_mid != 8'h00) |=> ((evt_mid_reg & $past(evt_mid)) == $past(evt_mid)))
        else $error("mid event lost on set");

    mid_clear_a: assert property (
        (rd_evt_mid && evt_mid == 8'h00) |=> (evt_mid_reg == 8'h00))
        else $error("mid event status not cleared by read");

    event_keep_a: assert property (
        !rd_evt_low |=> ((evt_low_reg & $past(evt_low_reg)) == $past(evt_low_reg)))
        else $error("low event bit dropped without a read");

    mid_keep_a: assert property (
        !rd_evt_mid |=> ((evt_mid_reg & $past(evt_mid_reg)) == $past(evt_mid_reg)))
        else $error("mid event bit dropped without a read");

    irq_fall_a: assert property (
        $fell(irq) |-> $past(rd_evt_low || rd_evt_mid || wr_msk_low || wr_msk_mid))
        else $error("interrupt fell without a read or mask write");

    irq_unmasked_a: assert property (
        ((evt_low & msk_low_reg) != 8'h00 && !wr_msk_low) |=> irq)
        else $error("unmasked event did not raise interrupt");

    unmapped_read_a: assert property (
        (reg_rd && !(hit_cfg || hit_sum_low || hit_sum_mid || hit_evt_low || hit_evt_mid ||
                     hit_msk_low || hit_msk_mid)) |=> (reg_rdata == rcb_pkg::RDATA_IDLE))
        else $error("unmapped read returned data");

    cfg_write_c: cover property (wr_cfg ##1 (reg_rd && hit_cfg));
    ext_select_c: cover property (!sel_in_range && ref_enable);
    irq_rise_c: cover property ($rose(irq));
    summary_read_c: cover property (reg_rd && hit_sum_mid && channel_irq_flags_mid != 8'h00);
    read_beside_set_c: cover property (rd_evt_low && evt_low != 8'h00);

endmodule : rcb_top

// file: testbench/test_ref_clock_b_select_irq_summary.sv
// Self-checking bench for the reference clock B select and channel interrupt summary bank
`timescale 1ns/1ps
module test_ref_clock_b_select_irq_summary;
    logic        clk;
    logic        arst_n;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic [7:0]  flags_low;
    logic [7:0]  flags_mid;
    logic [21:0] rec_clk;
    logic        ext_clk;
    logic        ref_out;
    logic        ref_oe_n;
    logic [11:0] rate_khz;
    logic        irq;
    logic [7:0]  rd_val;
    int          err_total;
    int          tests_run;

    rcb_top u_dut (
        .clk                       (clk),
        .arst_n                    (arst_n),
        .reg_addr                  (reg_addr),
        .reg_wdata                 (reg_wdata),
        .reg_wr                    (reg_wr),
        .reg_rd                    (reg_rd),
        .reg_rdata                 (reg_rdata),
        .channel_irq_flags_low     (flags_low),
        .channel_irq_flags_mid     (flags_mid),
        .recovered_clock_in        (rec_clk),
        .second_external_clock_in  (ext_clk),
        .second_reference_out      (ref_out),
        .second_reference_out_oe_n (ref_oe_n),
        .second_ext_clock_rate_khz (rate_khz),
        .irq                       (irq)
    );

    always #10 clk = ~clk;

    task automatic chk(input string what, input logic [11:0] got, input logic [11:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [11:0] a);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask : rd

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_cyc

    task automatic t_reset();
        rd(rcb_pkg::OFF_REF_CFG);
        chk("cfg reset", rd_val, 12'h041);
        chk("oe_n reset", ref_oe_n, 12'h000);
        chk("rate reset", rate_khz, 12'h608);
        rd(rcb_pkg::OFF_SUM_LOW);
        chk("sum low reset", rd_val, 12'h000);
        rd(rcb_pkg::OFF_SUM_MID);
        chk("sum mid reset", rd_val, 12'h000);
        rd(12'h7fc);
        chk("unmapped", rd_val, 12'h000);
        wait_cyc(1);
        chk("rdata idle", reg_rdata, 12'h000);
    endtask : t_reset

    task automatic t_config();
        wr(rcb_pkg::OFF_REF_CFG, 8'hff);
        rd(rcb_pkg::OFF_REF_CFG);
        chk("cfg bit7 dropped", rd_val, 12'h07f);
        chk("oe_n enabled", ref_oe_n, 12'h000);
        chk("rate e1", rate_khz, 12'h800);
        wr(rcb_pkg::OFF_REF_CFG, 8'h1f);
        wait_cyc(1);
        chk("oe_n disabled", ref_oe_n, 12'h001);
        chk("rate t1", rate_khz, 12'h608);
    endtask : t_config

    // Write then read with no gap between the strobes
    task automatic t_back2back();
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= rcb_pkg::OFF_REF_CFG;
        reg_wdata <= 8'hb5;
        @(posedge clk);
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b1;
        @(posedge clk);
        reg_rd    <= 1'b0;
        #1 rd_val = reg_rdata;
        chk("cfg back to back", rd_val, 12'h035);
        chk("oe_n back to back", ref_oe_n, 12'h001);
        chk("rate back to back", rate_khz, 12'h800);
    endtask : t_back2back

    task automatic t_reset_again();
        @(posedge clk);
        arst_n    <= 1'b0;
        flags_low <= 8'h00;
        flags_mid <= 8'h00;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
    endtask : t_reset_again

    task automatic t_route();
        logic [4:0] codes [6];
        codes = '{5'h00, 5'h01, 5'h14, 5'h15, 5'h16, 5'h1f};
        foreach (codes[i]) begin
            wr(rcb_pkg::OFF_REF_CFG, {3'h2, codes[i]});
            for (int v = 0; v < 2; v++) begin
                @(posedge clk);
                // Unselected sources carry the opposite level to expose a wrong pick
                if (codes[i] <= 5'h15) begin
                    rec_clk <= v ? (22'h1 << codes[i]) : ~(22'h1 << codes[i]);
                    ext_clk <= ~v[0];
                end else begin
                    rec_clk <= v ? 22'h0 : 22'h3fffff;
                    ext_clk <= v[0];
                end
                wait_cyc(6);
                chk("ref out level", ref_out, v[11:0]);
            end
        end
    endtask : t_route

    task automatic t_summary();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            flags_low <= 8'h01 << i;
            flags_mid <= ~(8'h01 << i);
            wait_cyc(2);
            rd(rcb_pkg::OFF_SUM_LOW);
            chk("sum low", rd_val, {4'h0, 8'h01 << i});
            rd(rcb_pkg::OFF_SUM_MID);
            chk("sum mid", rd_val, {4'h0, ~(8'h01 << i)});
        end
        wr(rcb_pkg::OFF_SUM_LOW, 8'h00);
        rd(rcb_pkg::OFF_SUM_LOW);
        chk("sum low write", rd_val, 12'h080);
    endtask : t_summary

    task automatic t_irq();
        @(posedge clk);
        flags_low <= 8'h00;
        flags_mid <= 8'h00;
        rd(rcb_pkg::OFF_EVT_LOW);
        rd(rcb_pkg::OFF_EVT_MID);
        wr(rcb_pkg::OFF_MSK_LOW, 8'h04);
        wr(rcb_pkg::OFF_MSK_MID, 8'h80);
        rd(rcb_pkg::OFF_MSK_LOW);
        chk("mask low", rd_val, 12'h004);
        rd(rcb_pkg::OFF_MSK_MID);
        chk("mask mid", rd_val, 12'h080);
        @(posedge clk);
        flags_low <= 8'h02;
        wait_cyc(4);
        chk("irq masked", irq, 12'h000);
        @(posedge clk);
        flags_low <= 8'h06;
        wait_cyc(4);
        chk("irq raised", irq, 12'h001);
        rd(rcb_pkg::OFF_EVT_LOW);
        chk("evt low", rd_val, 12'h006);
        wait_cyc(3);
        chk("irq cleared", irq, 12'h000);
        rd(rcb_pkg::OFF_EVT_LOW);
        chk("evt low clear", rd_val, 12'h000);
        @(posedge clk);
        flags_mid <= 8'h80;
        wait_cyc(4);
        chk("irq mid", irq, 12'h001);
        rd(rcb_pkg::OFF_EVT_MID);
        chk("evt mid", rd_val, 12'h080);
        // Event rising in the read cycle must survive the clear
        @(posedge clk);
        reg_rd    <= 1'b1;
        reg_addr  <= rcb_pkg::OFF_EVT_LOW;
        flags_low <= 8'h0e;
        @(posedge clk);
        reg_rd    <= 1'b0;
        #1 rd_val = reg_rdata;
        chk("evt read beside set", rd_val, 12'h000);
        rd(rcb_pkg::OFF_EVT_LOW);
        chk("evt set wins", rd_val, 12'h008);
    endtask : t_irq

    task automatic final_report();
        $display("Checks run %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        #1000000;
        err_total++;
        final_report();
    end

    initial begin
        clk       = 1'b0;
        arst_n    = 1'b0;
        reg_addr  = 12'h000;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        flags_low = 8'h00;
        flags_mid = 8'h00;
        rec_clk   = 22'h0;
        ext_clk   = 1'b0;
        err_total = 0;
        tests_run = 0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        t_reset();
        t_config();
        t_back2back();
        t_route();
        t_summary();
        t_irq();
        t_reset_again();
        final_report();
    end
endmodule : test_ref_clock_b_select_irq_summary
